// >>> shared/gdio_pkg.sv
// Constants shared by the general digital I/O port.
// Assumes a single I/O clock and a core that reaches the port by select lines.
// Notes on behaviour
// R1 - Output, direction registers RW; pin input RO
// R2 - Direction one makes output, zero input
// R3 - Input pull-up needs value one, no disable
// R4 - Global pull-up disable kills every pull-up
// R5 - Value zero or output turns pull-up off
// R6 - Output drives value bit, pull-up off
// R7 - Reset tri-states pins without a clock
// R8 - Pin input follows pin regardless of direction
// R9 - Latch transparent clock high, then registered
// R10 - Pin change seen after half to 1.5 clocks
// R11 - Written value reads back one clock later
// R12 - Bit set/clear touches only addressed pin
// R13 - Software steps via pull-up or output low
// R14 - Software steps via tri-state or output high
// R15 - Alternate function leaves other pins alone
// R16 - Deep sleep clamps input unless interrupt pin
// R17 - Register writes act on the completing edge
package gdio_pkg;
    localparam int          GDIO_WIDTH      = 8;
    localparam logic [7:0]  GDIO_VALUE_RST  = 8'h00;
    localparam logic [7:0]  GDIO_DIR_RST    = 8'h00;
    localparam logic [7:0]  GDIO_PIN_RST    = 8'h00;
    localparam logic [1:0]  GDIO_SEL_NONE   = 2'h0;
    localparam logic [1:0]  GDIO_SEL_VALUE  = 2'h1;
    localparam logic [1:0]  GDIO_SEL_DIR    = 2'h2;
    localparam logic [1:0]  GDIO_SEL_PIN    = 2'h3;
endpackage : gdio_pkg

// >>> rtl/gdio_port.sv
// General digital I/O port: value, direction and pin input registers.
// Assumes the core writes with byte write or single-bit set/clear strobes.
`timescale 1ns/1ns
`default_nettype none
module gdio_port
    import gdio_pkg::*;
#(
    parameter int WIDTH = gdio_pkg::GDIO_WIDTH
)
(
    // Clock and reset
    input  wire logic              clock_i,
    input  wire logic              srst_i,
    input  wire logic              clk_en_i,
    // Register access
    input  wire logic [1:0]        reg_sel_i,
    input  wire logic              wr_en_i,
    input  wire logic [WIDTH-1:0]  wr_data_i,
    input  wire logic              bit_set_i,
    input  wire logic              bit_clr_i,
    input  wire logic [2:0]        bit_idx_i,
    output logic      [WIDTH-1:0]  rd_data_o,
    // Global controls
    input  wire logic              global_pullup_disable_i,
    input  wire logic              deep_sleep_i,
    input  wire logic [WIDTH-1:0]  ext_int_en_i,
    // Pins
    input  wire logic [WIDTH-1:0]  pin_i,
    output logic      [WIDTH-1:0]  pin_o,
    output logic      [WIDTH-1:0]  pin_oe_o,
    output logic      [WIDTH-1:0]  pullup_en_o,
    // Register views
    output logic      [WIDTH-1:0]  port_output_value_o,
    output logic      [WIDTH-1:0]  port_direction_o,
    output logic      [WIDTH-1:0]  port_pin_input_o
);
    import gdio_pkg::*;

    // Register state
    logic [WIDTH-1:0] value_r;
    logic [WIDTH-1:0] value_nxt;
    logic [WIDTH-1:0] dir_r;
    logic [WIDTH-1:0] dir_nxt;
    logic [WIDTH-1:0] sync_latch;
    logic [WIDTH-1:0] pin_in_r;
    logic [WIDTH-1:0] rd_r;
    logic [WIDTH-1:0] rd_nxt;

    // Pin driver state
    logic [WIDTH-1:0] pin_o_r;
    logic [WIDTH-1:0] drv_nxt;
    logic [WIDTH-1:0] oe_r;
    logic [WIDTH-1:0] oe_nxt;
    logic [WIDTH-1:0] pu_r;
    logic [WIDTH-1:0] pu_nxt;
    logic [WIDTH-1:0] rst_gate;

    // Decoded selects and masks
    logic             sel_value;
    logic             sel_dir;
    logic             sel_pin;
    logic [WIDTH-1:0] bit_mask;
    logic [WIDTH-1:0] pud_mask;
    logic [WIDTH-1:0] sleep_mask;
    logic [WIDTH-1:0] clamped_in;

    // Byte write wins, then single-bit set, then single-bit clear
    function automatic logic [WIDTH-1:0] apply_write(
        input logic [WIDTH-1:0] cur,
        input logic             byte_wr,
        input logic [WIDTH-1:0] data,
        input logic             set,
        input logic             clr,
        input logic [WIDTH-1:0] mask
    );
        logic [WIDTH-1:0] res;
        res = cur;
        if (byte_wr)
        begin
            res = data;
        end
        else if (set)
        begin
            res = cur | mask; // R12
        end
        else if (clr)
        begin
            res = cur & ~mask; // R12
        end
        return res;
    endfunction : apply_write

    // One-hot mask of the pin addressed by a single-bit operation
    function automatic logic [WIDTH-1:0] onehot_bit(
        input logic [2:0] idx
    );
        logic [WIDTH-1:0] res;
        res = {WIDTH{1'b0}};
        res[idx] = 1'b1;
        return res;
    endfunction : onehot_bit

    // Pull-up only on inputs whose value bit is one, unless disabled
    function automatic logic [WIDTH-1:0] pullup_calc(
        input logic [WIDTH-1:0] dir,
        input logic [WIDTH-1:0] val,
        input logic [WIDTH-1:0] global_pullup_disable
    );
        logic [WIDTH-1:0] res;
        res = ~dir & val & ~global_pullup_disable; // R3 R4 R5
        return res;
    endfunction : pullup_calc

    // Register select decode
    assign sel_value  = (reg_sel_i == GDIO_SEL_VALUE);
    assign sel_dir    = (reg_sel_i == GDIO_SEL_DIR);
    assign sel_pin    = (reg_sel_i == GDIO_SEL_PIN);
    assign bit_mask   = onehot_bit(bit_idx_i);

    // Next register values
    assign value_nxt  = sel_value
                      ? apply_write(value_r, wr_en_i, wr_data_i,
                                    bit_set_i, bit_clr_i, bit_mask)
                      : value_r; // R1
    assign dir_nxt    = sel_dir
                      ? apply_write(dir_r, wr_en_i, wr_data_i,
                                    bit_set_i, bit_clr_i, bit_mask)
                      : dir_r; // R1

    // Read data: value and direction show the post-write contents
    assign rd_nxt     = sel_value ? value_nxt :
                        sel_dir   ? dir_nxt   :
                        sel_pin   ? pin_in_r  :
                        {WIDTH{1'b0}}; // R1

    // Pin driver next state
    assign pud_mask   = {WIDTH{global_pullup_disable_i}};
    assign drv_nxt    = value_nxt; // R6
    assign oe_nxt     = dir_nxt; // R2 R15
    assign pu_nxt     = pullup_calc(dir_nxt, value_nxt,
                                    pud_mask); // R3 R4 R5

    // Deep-sleep clamp ahead of the synchronizer
    assign sleep_mask = deep_sleep_i ? ext_int_en_i : {WIDTH{1'b1}};
    assign clamped_in = pin_i & sleep_mask; // R16

    // Latch transparent while clock high, holds while low
    always_latch
    begin
        if (clock_i)
        begin
            sync_latch <= clamped_in; // R9
        end
    end

    // Output value register
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            value_r <= GDIO_VALUE_RST;
        end
        else if (clk_en_i)
        begin
            value_r <= value_nxt; // R17
        end
    end

    // Direction register
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            dir_r <= GDIO_DIR_RST;
        end
        else if (clk_en_i)
        begin
            dir_r <= dir_nxt; // R17
        end
    end

    // Pin input register, second stage of the synchronizer
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            pin_in_r <= GDIO_PIN_RST;
        end
        else if (clk_en_i)
        begin
            pin_in_r <= sync_latch; // R8 R10 R11
        end
    end

    // Registered read data
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            rd_r <= {WIDTH{1'b0}};
        end
        else if (clk_en_i)
        begin
            rd_r <= rd_nxt;
        end
    end

    // Drive value
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            pin_o_r <= {WIDTH{1'b0}};
        end
        else if (clk_en_i)
        begin
            pin_o_r <= drv_nxt; // R6
        end
    end

    // Drive enable
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            oe_r <= {WIDTH{1'b0}}; // R7
        end
        else if (clk_en_i)
        begin
            oe_r <= oe_nxt; // R2
        end
    end

    // Pull-up enable
    always_ff @(posedge clock_i)
    begin
        if (srst_i)
        begin
            pu_r <= {WIDTH{1'b0}}; // R7
        end
        else if (clk_en_i)
        begin
            pu_r <= pu_nxt; // R3 R5
        end
    end

    // Asynchronous tri-state gate so reset acts with no clock running
    assign rst_gate            = {WIDTH{~srst_i}};
    assign pin_o               = pin_o_r & rst_gate;
    assign pin_oe_o            = oe_r & rst_gate; // R7
    assign pullup_en_o         = pu_r & rst_gate; // R7

    // Register views
    assign rd_data_o           = rd_r;
    assign port_output_value_o = value_r;
    assign port_direction_o    = dir_r;
    assign port_pin_input_o    = pin_in_r;
endmodule : gdio_port
`default_nettype wire

// >>> verif/gdio_ext_model.sv
// Outside circuitry on the port pins: drivers and pull-up.
// Assumes the bench picks the pins it drives from outside.
`timescale 1ns/1ns
`default_nettype none
module gdio_ext_model (
    input  wire logic [7:0] pin_o, pin_oe_o, pullup_en_o, ext_drv_i, ext_en_i,
    output logic      [7:0] pin_i
);
    assign pin_i = pin_oe_o & pin_o | ~pin_oe_o & (ext_en_i & ext_drv_i
        | ~ext_en_i & (pullup_en_o | ~pin_o));
endmodule : gdio_ext_model
`default_nettype wire

// >>> verif/gdio_port_assertions.sv
// Checker: pin control, register writes and input sync of the port.
// Assumes one clock; bound to every port instance.
`timescale 1ns/1ns
`default_nettype none
module gdio_chk
    import gdio_pkg::*;
(
    input wire logic clock_i, srst_i, clk_en_i, wr_en_i, deep_sleep_i,
    input wire logic global_pullup_disable_i,
    input wire logic [1:0] reg_sel_i,
    input wire logic [7:0] wr_data_i, ext_int_en_i, pin_i, pin_o, pin_oe_o,
    input wire logic [7:0] pullup_en_o, port_output_value_o,
    input wire logic [7:0] port_direction_o, port_pin_input_o
);
    logic [7:0] fq;
    always_ff @(negedge clock_i)
        fq <= pin_i & (ext_int_en_i | {8{!deep_sleep_i}});
    default clocking @(posedge clock_i); endclocking
    default disable iff (srst_i);
    a_oe_dir: assert property (pin_oe_o == port_direction_o)
        else $error("oe");
    a_drive_val: assert property (
        !(pin_oe_o & (pin_o ^ port_output_value_o))) else $error("drive");
    a_pud_kill: assert property (
        $past(global_pullup_disable_i) |-> !pullup_en_o) else $error("pud");
    a_pull_rule: assert property (
        !$past(global_pullup_disable_i) && $past(clk_en_i) |-> pullup_en_o
        == (port_output_value_o & ~port_direction_o)) else $error("pull");
    a_dir_write: assert property (
        wr_en_i && clk_en_i && reg_sel_i == GDIO_SEL_DIR
        |=> port_direction_o == $past(wr_data_i)) else $error("dir");
    a_pin_ro: assert property (
        reg_sel_i == GDIO_SEL_PIN |=> $stable(port_direction_o)
        && $stable(port_output_value_o)) else $error("ro");
    a_pin_sync: assert property (
        $past(clk_en_i) && !$past(srst_i) |-> port_pin_input_o == $past(fq))
        else $error("sync");
    a_reset_tri: assert property (disable iff (1'b0)
        srst_i |-> !pin_oe_o && !pullup_en_o) else $error("reset");
endmodule : gdio_chk
bind gdio_port gdio_chk u_chk (.*);
`default_nettype wire

// >>> verif/general_digital_io_port_bench.sv
// Bench: pin states, bit ops, input sync, sleep clamp and reset.
// Assumes the pin model at the pins and the bound checker.
`timescale 1ns/1ns
`default_nettype none
module general_digital_io_port_bench;
    import gdio_pkg::*;
    logic clock_i = 0, srst_i = 1, wr_en_i = 0, bit_set_i = 0, bit_clr_i = 0;
    logic deep_sleep_i = 0, global_pullup_disable_i = 0;
    logic [1:0] reg_sel_i = '0;
    logic [2:0] bit_idx_i = '0;
    logic [7:0] wr_data_i = '0, ext_int_en_i = '0, ext_drv_i = '0;
    logic [7:0] ext_en_i = '0, pin_i, pin_o, pin_oe_o, pullup_en_o;
    logic [7:0] port_output_value_o, port_direction_o, port_pin_input_o;
    logic [7:0] rd_data_o;
    logic clk_en_i = 1;
    int fail_count = 0, n_compared = 0;
    gdio_port DUT (.*);
    gdio_ext_model u_ext (.*);
    initial forever #4 clock_i = ~clock_i;
    task automatic chk(string nm, logic [7:0] e, g);
        n_compared++;
        fail_count += int'(g !== e);
        if (g !== e) $display("[ERR] %s exp %h got %h", nm, e, g);
    endtask : chk
    task automatic put(logic [1:0] s, logic [2:0] o, logic [7:0] d);
        @(posedge clock_i);
        reg_sel_i <= s;
        {wr_en_i, bit_set_i, bit_clr_i} <= o;
        {wr_data_i, bit_idx_i} <= {d, d[2:0]};
        @(posedge clock_i);
        reg_sel_i <= GDIO_SEL_NONE;
        #1;
    endtask : put
    task automatic t_modes;
        logic [1:0] m [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
        foreach (m[i])
        begin
            put(GDIO_SEL_VALUE, 3'h4, {8{m[i][0]}});
            put(GDIO_SEL_DIR, 3'h4, {8{m[i][1]}});
            chk("oe", {8{m[i][1]}}, pin_oe_o);
            chk("pull", {8{m[i] == 2'h1}}, pullup_en_o);
            chk("drive", {8{m[i] == 2'h3}}, pin_o & pin_oe_o);
            chk("rd", {8{m[i] != 2'h2}}, port_pin_input_o | {8{!m[i]}});
        end
        put(GDIO_SEL_VALUE, 3'h4, 8'ha5);
        put(GDIO_SEL_VALUE, 3'h1, 8'h05);
        put(GDIO_SEL_DIR, 3'h2, 8'h03);
        chk("rd_data", 8'h08, rd_data_o);
        put(GDIO_SEL_PIN, 3'h4, 8'hff);
        @(posedge clock_i);
        clk_en_i <= 1'b0;
        put(GDIO_SEL_DIR, 3'h4, 8'hff);
        chk("frozen", 8'h08, port_direction_o);
        @(posedge clock_i);
        clk_en_i <= 1'b1;
        chk("value", 8'h85, port_output_value_o);
        chk("dir", 8'h08, port_direction_o);
    endtask : t_modes
    task automatic t_input;
        @(posedge clock_i);
        {global_pullup_disable_i, ext_en_i, ext_drv_i} <= 17'h1f75a;
        @(posedge clock_i);
        #1;
        chk("sync", 8'h52, port_pin_input_o);
        chk("pud", 8'h00, pullup_en_o);
        @(posedge clock_i);
        {global_pullup_disable_i, deep_sleep_i, ext_int_en_i} <= 10'h150;
        @(posedge clock_i);
        #1;
        chk("clamp", 8'h50, port_pin_input_o);
        chk("pull", 8'h85, pullup_en_o);
        @(posedge clock_i);
        srst_i <= 1'b1;
        #1;
        chk("tri", 8'h00, pin_oe_o | pullup_en_o);
    endtask : t_input
    task automatic end_of_test;
        $display("compared %0d failed %0d", n_compared, fail_count);
        if (fail_count == 0 && n_compared > 0)
            $display("TEST PASSED");
        else
            $display("TEST FAILED");
        $finish;
    endtask : end_of_test
    initial
    begin
        #5000;
        fail_count++;
        end_of_test();
    end
    initial
    begin
        repeat (3) @(posedge clock_i);
        srst_i <= 1'b0;
        t_modes();
        t_input();
        @(posedge clock_i);
        srst_i <= 1'b0;
        #1;
        chk("rst", GDIO_DIR_RST, port_direction_o);
        end_of_test();
    end
endmodule : general_digital_io_port_bench
`default_nettype wire
